/* trim_comp_control.sv */
// Purpose: Temperature compensation sequencing and trim registers.
// Assumes: Sensor values arrive already sampled on core_clk; pins synced here.
// Notes:   Register reads answer one cycle after the read strobe.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module trim_comp_control
    import trim_pkg::*;
#(
    parameter longint CONVERT_COUNT = CONVERT_CYCLES,
    parameter longint SLOW_COUNT    = SLOW_PERIOD_CYC,
    parameter longint FAST_COUNT    = FAST_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // Supply status pins
    input  wire logic       on_battery,
    input  wire logic       battery_low,
    // Temperature sensor
    input  wire logic [9:0] sensor_value,
    output logic            sensor_power,
    output logic [9:0]      temp_result,
    // Oscillator control
    output logic [5:0]      analog_trim_setting,
    output logic [4:0]      digital_trim_setting,
    output logic            busy
);
    // ****************************************
    // Parameter checks
    // ****************************************
    initial begin
        if (CONVERT_COUNT < 2 || CONVERT_COUNT >= (64'd1 << 23)) begin
            $error("trim_comp_control: bad conversion count");
        end
    end

    localparam longint HALF_COUNT = CONVERT_COUNT / 2; // Half of one conversion
    localparam logic [22:0] HALF_LAST = 23'(HALF_COUNT - 1);

    // ****************************************
    // Registers
    // ****************************************
    logic [5:0]    initial_analog_trim;  // Initial analog code
    logic [1:0]    initial_digital_trim; // Initial digital code
    logic [7:0]    curvature;            // Scaled coefficient magnitude
    logic          sense_enable;         // Main sensing enable
    logic          battery_sense_enable; // Battery-mode enable
    logic          battery_sense_rate;   // Battery-mode fast period
    logic [4:0]    gain;                 // Analog step gain
    logic [5:0]    final_analog_trim;    // Corrected analog code
    logic [4:0]    final_digital_trim;   // Corrected digital code
    logic          comp_valid;           // A compensation result is held
    seq_state_type state;                // Conversion sequencer
    logic [22:0]   conv_count;           // Conversion elapsed cycles
    logic [10:0]   conv_sum;             // Sum of two samples
    logic          start_pulse;          // Request a sequence
    logic          corr_done;            // Correction finished
    logic [5:0]    corr_analog;          // Corrected analog result
    logic [4:0]    corr_digital;         // Corrected digital result
    logic          period_tick;          // Battery period elapsed
    logic          battery_run;          // Battery sensing permitted
    logic [1:0]    battery_sync;         // Pin synchroniser
    logic [1:0]    low_sync;             // Pin synchroniser
    logic          write_control;        // Write hits control register

    // Supply pins cross into the core clock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            battery_sync <= 2'b00;
            low_sync     <= 2'b00;
        end else begin
            battery_sync <= {battery_sync[0], on_battery};
            low_sync     <= {low_sync[0], battery_low};
        end
    end

    assign write_control = reg_write && reg_addr == OFS_CONTROL_GAIN;

    // ****************************************
    // Register writes
    // ****************************************
    // Settings are writable any time; keeping sensing off is software's job
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            initial_analog_trim  <= RESET_INIT_TRIM[5:0];
            initial_digital_trim <= RESET_INIT_TRIM[7:6];
            curvature            <= RESET_CURVATURE;
            sense_enable         <= RESET_CONTROL_GAIN[BIT_SENSE_ENABLE];
            battery_sense_enable <= RESET_CONTROL_GAIN[BIT_BATTERY_ENABLE];
            battery_sense_rate   <= RESET_CONTROL_GAIN[BIT_BATTERY_RATE];
            gain                 <= RESET_CONTROL_GAIN[4:0];
        end else if (reg_write) begin
            case (reg_addr)
                OFS_INIT_TRIM: begin
                    initial_analog_trim  <= reg_wdata[5:0];
                    initial_digital_trim <= reg_wdata[7:6];
                end
                OFS_CURVATURE: begin
                    curvature <= reg_wdata;
                end
                OFS_CONTROL_GAIN: begin
                    sense_enable         <= reg_wdata[BIT_SENSE_ENABLE];
                    battery_sense_enable <= reg_wdata[BIT_BATTERY_ENABLE];
                    battery_sense_rate   <= reg_wdata[BIT_BATTERY_RATE];
                    gain                 <= reg_wdata[4:0];
                end
                // Final trims are read only, writes dropped
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Sequence requests
    // ****************************************
    // Battery sensing needs enable and a healthy battery
    assign battery_run = battery_sync[1] && battery_sense_enable && !low_sync[1];

    trim_period_timer #(
        .WIDTH      (38),
        .SLOW_COUNT (SLOW_COUNT),
        .FAST_COUNT (FAST_COUNT)
    ) u_period (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (battery_run),
        .fast     (battery_sense_rate),
        .tick     (period_tick)
    );

    // A write setting the enable starts a sequence, as does the battery period
    assign start_pulse = (write_control && reg_wdata[BIT_SENSE_ENABLE])
                         || (period_tick && sense_enable);

    // ****************************************
    // Conversion sequencer
    // ****************************************
    // Two equal halves fill the 22 ms; battery uses the same timing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state      <= ST_IDLE;
            conv_count <= '0;
            conv_sum   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    conv_count <= '0;
                    if (start_pulse) begin
                        state    <= ST_CONV1;
                        conv_sum <= '0;
                    end
                end
                ST_CONV1: begin
                    if (conv_count == HALF_LAST) begin
                        conv_count <= '0;
                        conv_sum   <= {1'b0, sensor_value};
                        state      <= ST_CONV2;
                    end else begin
                        conv_count <= conv_count + 1'b1;
                    end
                end
                ST_CONV2: begin
                    if (conv_count == HALF_LAST) begin
                        conv_count <= '0;
                        conv_sum   <= conv_sum + {1'b0, sensor_value};
                        state      <= ST_LOAD;
                    end else begin
                        conv_count <= conv_count + 1'b1;
                    end
                end
                ST_LOAD: begin
                    if (corr_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign busy         = state != ST_IDLE;
    assign sensor_power = state == ST_CONV1 || state == ST_CONV2;

    // Average of the two samples
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            temp_result <= '0;
        end else if (state == ST_CONV2 && conv_count == HALF_LAST) begin
            temp_result <= 10'((conv_sum + {1'b0, sensor_value}) >> 1);
        end
    end

    // ****************************************
    // Trim correction
    // ****************************************
    trim_correction u_correction (
        .core_clk     (core_clk),
        .reset        (reset),
        .start        (state == ST_LOAD && !corr_done),
        .init_analog  (initial_analog_trim),
        .init_digital (initial_digital_trim),
        .curvature    (curvature),
        .gain         (gain < GAIN_LOW_VALID || gain[4] ? gain : GAIN_LOW_VALID),
        .temp_delta   (temp_result),
        .done         (corr_done),
        .analog_out   (corr_analog),
        .digital_out  (corr_digital)
    );

    // Both finals load together at the end of a cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            final_analog_trim  <= ANALOG_ZERO_CODE;
            final_digital_trim <= 5'h00;
            comp_valid         <= 1'b0;
        end else if (corr_done) begin
            final_analog_trim  <= corr_analog;
            final_digital_trim <= corr_digital;
            comp_valid         <= 1'b1;
        end
    end

    // Disabled sensing drives the initial trims straight through
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            analog_trim_setting  <= RESET_INIT_TRIM[5:0];
            digital_trim_setting <= 5'h00;
        end else if (sense_enable && comp_valid) begin
            analog_trim_setting  <= final_analog_trim;
            digital_trim_setting <= final_digital_trim;
        end else begin
            analog_trim_setting  <= initial_analog_trim;
            digital_trim_setting <= {initial_digital_trim[1] & initial_digital_trim[0], 3'b000,
                                     initial_digital_trim[0]};
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_INIT_TRIM:     reg_rdata <= {initial_digital_trim, initial_analog_trim};
                OFS_CURVATURE:     reg_rdata <= curvature;
                OFS_CONTROL_GAIN:  reg_rdata <= {sense_enable, battery_sense_enable,
                                                 battery_sense_rate, gain};
                OFS_FINAL_ANALOG:  reg_rdata <= {2'b00, final_analog_trim};
                OFS_FINAL_DIGITAL: reg_rdata <= {3'b000, final_digital_trim};
                OFS_STATUS:        reg_rdata <= {6'h00, comp_valid, busy};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    enable_starts_a: assert property (@(posedge core_clk) disable iff (reset)
        (state == ST_IDLE && write_control && reg_wdata[BIT_SENSE_ENABLE])
        |=> state == ST_CONV1)
        else $error("sense enable write did not start conversion");

    final_readonly_a: assert property (@(posedge core_clk) disable iff (reset)
        !corr_done |=> $stable(final_analog_trim))
        else $error("final analog trim changed outside compensation");

    disabled_direct_a: assert property (@(posedge core_clk) disable iff (reset)
        !sense_enable |=> analog_trim_setting == $past(initial_analog_trim))
        else $error("disabled sensing not using initial trim");

    low_battery_a: assert property (@(posedge core_clk) disable iff (reset)
        low_sync[1] |-> !battery_run)
        else $error("battery sensing active with low battery");

    reset_enable_a: assert property (@(posedge core_clk)
        $fell(reset) |-> !sense_enable && !battery_sense_enable)
        else $error("enables not cleared after reset");

    read_high_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        (reg_read && reg_addr == OFS_FINAL_ANALOG) |=> reg_rdata[7:6] == 2'b00
        && reg_rdata[5:0] == $past(final_analog_trim))
        else $error("final analog read wrong");

    conv_length_a: assert property (@(posedge core_clk) disable iff (reset)
        (state == ST_CONV1 && conv_count == HALF_LAST) |=> state == ST_CONV2 && conv_count == 0)
        else $error("conversion half length wrong");

    single_update_a: assert property (@(posedge core_clk) disable iff (reset)
        corr_done |=> final_analog_trim == $past(corr_analog)
        && final_digital_trim == $past(corr_digital))
        else $error("final trims not loaded together");
endmodule

/* trim_comp_control_test.sv */
// Purpose: Self-checking bench for the trim compensation control block.
// Assumes: Shortened conversion and battery period counts (20, 200 and 40 cycles).
// Notes:   Inputs change by non-blocking assignment, at the rising edge or 1 ns after it.
`timescale 1ns/10ps
module trim_comp_control_test;
    import trim_pkg::*;
    // ****************************************
    // Signals and instance
    // ****************************************
    localparam longint CONV = 20;       // Shortened conversion span
    logic       core_clk;               // 200 MHz clock
    logic       reset;                  // Async reset, active high
    logic [7:0] reg_addr;               // Register address
    logic [7:0] reg_wdata;              // Register write data
    logic       reg_write;              // Write strobe
    logic       reg_read;               // Read strobe
    logic [7:0] reg_rdata;              // Read data
    logic       on_battery;             // Battery mode pin
    logic       battery_low;            // Battery below threshold
    logic [9:0] sensor_value;           // Sensor sample
    logic       sensor_power;           // Sensor powered
    logic [9:0] temp_result;            // Averaged temperature
    logic [5:0] analog_trim_setting;    // Oscillator analog trim
    logic [4:0] digital_trim_setting;   // Oscillator digital trim
    logic       busy;                   // Sequence running
    int         failures;               // Mismatch count
    int         cmp_count;              // Comparison count
    int         w_main;                 // Busy span of a main-supply sequence

    trim_comp_control #(.CONVERT_COUNT(CONV), .SLOW_COUNT(200), .FAST_COUNT(40))
        trim_comp_control_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .on_battery(on_battery), .battery_low(battery_low),
        .sensor_value(sensor_value), .sensor_power(sensor_power), .temp_result(temp_result),
        .analog_trim_setting(analog_trim_setting), .digital_trim_setting(digital_trim_setting),
        .busy(busy));
    // ****************************************
    // Shared tasks
    // ****************************************
    // Let one edge pass and its updates settle
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Wait for a sequence, then measure how long busy stays up
    task automatic wait_busy(output int w, output logic sp);
        int g;
        g = 0; w = 0;
        #1;
        while (busy !== 1'b1 && g < 300) begin tick(); g++; end
        sp = sensor_power;
        while (busy === 1'b1 && w < 1000) begin tick(); w++; end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset;
        logic [7:0] d;
        rd(OFS_CURVATURE, d);    check("curvature", d, 16'h0);
        rd(OFS_CONTROL_GAIN, d); check("control", d, 16'h0);
        rd(OFS_FINAL_ANALOG, d); check("final_analog", d, 16'(ANALOG_ZERO_CODE));
        check("busy_idle", busy, 16'h0);
        check("power_idle", sensor_power, 16'h0);
        $display("test_reset done");
    endtask
    task automatic test_direct;
        logic [7:0] d;
        wr(OFS_INIT_TRIM, 8'h65);
        tick(); tick();
        check("direct_analog", analog_trim_setting, 16'h25);
        check("direct_digital", digital_trim_setting, 16'h01);
        wr(OFS_CURVATURE, 8'h46); rd(OFS_CURVATURE, d);
        check("curvature_rw", d, 16'h46);
        wr(OFS_FINAL_ANALOG, 8'hFF); rd(OFS_FINAL_ANALOG, d);
        check("final_ro", d, 16'(ANALOG_ZERO_CODE));
        rd(8'h30, d); check("unmapped", d, 16'h0);
        wr(OFS_CONTROL_GAIN, 8'h1F); rd(OFS_CONTROL_GAIN, d);
        check("gain_top", d, 16'h1F);
        $display("test_direct done");
    endtask
    task automatic test_sense;
        logic [7:0] d;
        logic       sp;
        sensor_value <= 10'h155;
        wr(OFS_CURVATURE, 8'h00);
        wr(OFS_CONTROL_GAIN, 8'h08);
        wr(OFS_CONTROL_GAIN, 8'h88);
        wait_busy(w_main, sp);
        check("sensor_on", sp, 16'h1);
        check("conv_span", (w_main >= CONV && w_main <= CONV + 3), 16'h1);
        tick(); tick();
        check("average", temp_result, 16'h155);
        rd(OFS_FINAL_ANALOG, d);
        check("final_top", d[7:6], 16'h0);
        check("final_follow", d[5:0], 16'h25);
        check("trim_analog", analog_trim_setting, 16'h25);
        check("trim_digital", digital_trim_setting, 16'h01);
        rd(OFS_FINAL_DIGITAL, d);
        check("final_digital", d, 16'h01);
        rd(OFS_STATUS, d);
        check("status_done", d, 16'h02);
        $display("test_sense done");
    endtask
    // Count sequence starts over 400 cycles in battery mode
    task automatic window(input logic [7:0] ctl, input logic low, output int starts);
        logic prev;
        wr(OFS_CONTROL_GAIN, 8'h08);
        on_battery <= 1'b1; battery_low <= low;
        repeat (30) tick();
        wr(OFS_CONTROL_GAIN, ctl);
        repeat (30) tick();
        starts = 0; prev = busy;
        repeat (400) begin
            tick();
            if (busy === 1'b1 && prev !== 1'b1) starts++;
            prev = busy;
        end
    endtask
    task automatic test_battery;
        int   n;
        int   w;
        logic sp;
        window(8'hE8, 1'b0, n);
        check("fast_rate", (n >= 9 && n <= 11), 16'h1);
        wait_busy(w, sp);
        check("battery_span", (w == w_main), 16'h1);
        window(8'hC8, 1'b0, n);
        check("slow_rate", (n >= 1 && n <= 3), 16'h1);
        window(8'h88, 1'b0, n);
        check("battery_off", n, 16'h0);
        window(8'hE8, 1'b1, n);
        check("battery_low", n, 16'h0);
        on_battery <= 1'b0; battery_low <= 1'b0;
        $display("test_battery done");
    endtask
    // ****************************************
    // Clock, sequence, watchdog, verdict
    // ****************************************
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Main sequence: all inputs defined at time zero
    initial begin
        failures = 0; cmp_count = 0; w_main = 0;
        reset = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_write = 1'b0;
        reg_read = 1'b0; on_battery = 1'b0; battery_low = 1'b0; sensor_value = 10'h000;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        test_reset();
        test_direct();
        test_sense();
        test_battery();
        summarize();
    end
    // Tests need about 2000 cycles; allow far more before cutting a hang
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule

/* trim_correction.sv */
// Purpose: Computes corrected analog trim from temperature and decodes the initial digital trim.
// Assumes: Inputs stable while start is high.
// Notes:   Result registered one cycle after start.
`timescale 1ns/10ps
module trim_correction
    import trim_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Inputs
    input  wire logic       start,
    input  wire logic [5:0] init_analog,
    input  wire logic [1:0] init_digital,
    input  wire logic [7:0] curvature,
    input  wire logic [4:0] gain,
    input  wire logic [9:0] temp_delta,
    // Results
    output logic            done,
    output logic [5:0]      analog_out,
    output logic [4:0]      digital_out
);
    // ****************************************
    // Arithmetic helpers
    // ****************************************
    // Gain in sixteenths: 0..8 shrink from 16, 16..31 grow from 17
    function automatic logic [5:0] gain_sixteenths(input logic [4:0] g);
        if (g[4]) begin
            gain_sixteenths = 6'(17 + g[3:0]);
        end else begin
            gain_sixteenths = 6'(16 - g[3:0]);
        end
    endfunction

    logic signed [31:0] shift_ppm;  // Curvature shift, ppm
    logic signed [31:0] code_delta; // Shift in analog code units
    logic signed [31:0] code_full;  // Unclamped analog code

    // Quadratic pull: coefficient/2048 times delta squared
    always_comb begin
        shift_ppm  = (32'(curvature) * 32'(temp_delta) * 32'(temp_delta)) >>> 11;
        code_delta = (shift_ppm * 16) / 32'(gain_sixteenths(gain));
        // Frequency falls with temperature away from turnover: lower code by the shift toward +ppm
        code_full  = 32'(init_analog) - code_delta;
    end

    // ****************************************
    // Result register
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done        <= 1'b0;
            analog_out  <= ANALOG_ZERO_CODE;
            digital_out <= 5'h00;
        end else begin
            done <= start;
            if (start) begin
                analog_out  <= (code_full < 0) ? 6'h00 : 6'(code_full);
                // Digital code 01 is one step up, 11 one step down, others zero
                digital_out <= {init_digital[1] & init_digital[0], 3'b000, init_digital[0]};
            end
        end
    end
endmodule

/* trim_period_timer.sv */
// Purpose: Battery-mode periodic sensing timer.
// Assumes: Counts on every core clock.
// Notes:   Restarts whenever it is not enabled.
`timescale 1ns/10ps
module trim_period_timer
    import trim_pkg::*;
#(
    parameter int          WIDTH      = 38,
    parameter longint      SLOW_COUNT = SLOW_PERIOD_CYC,
    parameter longint      FAST_COUNT = FAST_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Control
    input  wire logic run,
    input  wire logic fast,
    // Event
    output logic      tick
);
    // ****************************************
    // Period counter
    // ****************************************
    logic [WIDTH-1:0] count; // Cycles since last tick
    logic [WIDTH-1:0] limit; // Selected period minus one

    initial begin
        if (SLOW_COUNT < 2 || FAST_COUNT < 2 || SLOW_COUNT >= (64'd1 << WIDTH)) begin
            $error("trim_period_timer: bad period parameters");
        end
    end

    // Rate bit picks the period length
    assign limit = fast ? WIDTH'(FAST_COUNT - 1) : WIDTH'(SLOW_COUNT - 1);

    // Counter holds at zero while idle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

/* trim_pkg.sv */
// Purpose: Shared constants for the oscillator trim compensation control block.
// Assumes: 200 MHz core clock, 8-bit register port.
// Notes:   Offsets are byte addresses on the plain register port.
package trim_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_INIT_TRIM      = 8'h0B; // Initial analog/digital trim
    localparam logic [7:0] OFS_CURVATURE      = 8'h0C; // Cold curvature coefficient
    localparam logic [7:0] OFS_CONTROL_GAIN   = 8'h0D; // Control and gain
    localparam logic [7:0] OFS_FINAL_ANALOG   = 8'h0E; // Final analog trim, read only
    localparam logic [7:0] OFS_FINAL_DIGITAL  = 8'h0F; // Final digital trim, read only
    localparam logic [7:0] OFS_STATUS         = 8'h20; // Sequencer status
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int BIT_SENSE_ENABLE   = 7;
    localparam int BIT_BATTERY_ENABLE = 6;
    localparam int BIT_BATTERY_RATE   = 5;
    localparam logic [7:0] RESET_CONTROL_GAIN = 8'h00;
    localparam logic [7:0] RESET_CURVATURE    = 8'h00;
    localparam logic [7:0] RESET_INIT_TRIM    = 8'h00;
    localparam logic [5:0] ANALOG_ZERO_CODE   = 6'h20;
    localparam logic [4:0] GAIN_LOW_VALID     = 5'h08;
    // ****************************************
    // Timing
    // ****************************************
    localparam longint CLOCK_HZ        = 200000000;
    localparam longint CONVERT_TIME_MS = 22;
    localparam longint CONVERT_CYCLES  = CLOCK_HZ * CONVERT_TIME_MS / 1000;
    localparam longint SLOW_PERIOD_MIN = 10;
    localparam longint FAST_PERIOD_MIN = 1;
    localparam longint SLOW_PERIOD_CYC = CLOCK_HZ * 60 * SLOW_PERIOD_MIN;
    localparam longint FAST_PERIOD_CYC = CLOCK_HZ * 60 * FAST_PERIOD_MIN;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV1 = 2'b01,
        ST_CONV2 = 2'b11,
        ST_LOAD  = 2'b10
    } seq_state_type;
endpackage
